// [bcf_pkg.sv]
/*
  shared constants, types and decode helpers for the configuration
  forwarding block of a two-port bus bridge.
  assumes one clock; all bus signals are already sampled on that clock.
*/
package bcf_pkg;

  localparam logic [3:0] CMD_SPC    = 4'h1;
  localparam logic [3:0] CMD_CFG_RD = 4'ha;
  localparam logic [3:0] CMD_CFG_WR = 4'hb;

  localparam logic [1:0] AD_TYPE0   = 2'h0;
  localparam logic [1:0] AD_TYPE1   = 2'h1;
  localparam logic [4:0] DEV_SPC    = 5'h1f;
  localparam logic [2:0] FN_SPC     = 3'h7;
  localparam logic [5:0] REG_SPC    = 6'h00;
  localparam logic [4:0] IDSEL_DEVS = 5'h10;

  localparam logic [31:0] RST_WORD  = 32'h0000_0000;
  localparam logic [3:0]  RST_NIB   = 4'h0;
  localparam logic [7:0]  RST_BYTE  = 8'h00;

  typedef enum logic [2:0] {
    CLS_NONE   = 3'b000,
    CLS_OWN    = 3'b001,
    CLS_T0     = 3'b010,
    CLS_T1_DN  = 3'b011,
    CLS_T1_UP  = 3'b100,
    CLS_SPC_DN = 3'b101,
    CLS_SPC_UP = 3'b110
  } bcf_cls_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DEC  = 2'b01,
    ST_DATA = 2'b10,
    ST_TERM = 2'b11
  } bcf_state_t;

  function automatic logic bcf_is_cfg(input logic [3:0] cmd);
    bcf_is_cfg = (cmd == CMD_CFG_RD) || (cmd == CMD_CFG_WR);
  endfunction : bcf_is_cfg

endpackage : bcf_pkg

// [bcf_cfg_decode.sv]
/*
  address phase decoder: classifies a configuration access and builds
  the address and command to issue on the far bus. results are held
  in registers until the next start.
  assumes start_i is a one-cycle pulse in the address phase.
*/
`timescale 1ns/100ps
module bcf_cfg_decode (
  input  wire logic            clk_i,
  input  wire logic            rst_n_i,
  input  wire logic            start_i,
  input  wire logic            from_sec_i,
  input  wire logic [31:0]     ad_i,
  input  wire logic [3:0]      cbe_i,
  input  wire logic            idsel_i,
  input  wire logic [7:0]      pri_bus_i,
  input  wire logic [7:0]      sec_bus_i,
  input  wire logic [7:0]      sub_bus_i,
  output bcf_pkg::bcf_cls_t    cls_o,
  output logic      [31:0]     oaddr_o,
  output logic      [3:0]      ocmd_o,
  output logic      [31:0]     xaddr_o,
  output logic      [3:0]      xcmd_o
);

  function automatic logic [15:0] idsel_pat(input logic [4:0] dev);
    idsel_pat = 16'h0000;
    if (dev < bcf_pkg::IDSEL_DEVS) begin
      idsel_pat[dev[3:0]] = 1'b1; // [R10] [R11]
    end
  endfunction : idsel_pat

  logic [7:0]        bus;
  logic [4:0]        dev;
  logic [2:0]        fn;
  logic [5:0]        regn;
  logic              cfg;
  logic              wr;
  logic              spc_addr;
  logic              in_rng;
  bcf_pkg::bcf_cls_t cls_d;

  assign bus      = ad_i[23:16];
  assign dev      = ad_i[15:11];
  assign fn       = ad_i[10:8];
  assign regn     = ad_i[7:2];
  assign cfg      = bcf_pkg::bcf_is_cfg(cbe_i); // [R17]
  assign wr       = (cbe_i == bcf_pkg::CMD_CFG_WR);
  assign spc_addr = (dev == bcf_pkg::DEV_SPC) && (fn == bcf_pkg::FN_SPC);
  assign in_rng   = (bus >= sec_bus_i) && (bus <= sub_bus_i);

  always_comb begin
    cls_d = bcf_pkg::CLS_NONE;
    if (cfg && !from_sec_i) begin
      if (ad_i[1:0] == bcf_pkg::AD_TYPE0 && idsel_i) begin
        cls_d = bcf_pkg::CLS_OWN; // [R01] [R03]
      end else if (ad_i[1:0] == bcf_pkg::AD_TYPE1) begin
        if (wr && spc_addr && regn == bcf_pkg::REG_SPC && bus == sec_bus_i) begin
          cls_d = bcf_pkg::CLS_SPC_DN; // [R18] [R12]
        end else if (bus == sec_bus_i) begin
          cls_d = bcf_pkg::CLS_T0; // [R07] [R08]
        end else if (bus > sec_bus_i && bus <= sub_bus_i) begin
          cls_d = bcf_pkg::CLS_T1_DN; // [R14]
        end
      end
    end else if (cfg && wr && ad_i[1:0] == bcf_pkg::AD_TYPE1 && spc_addr) begin
      if (regn == bcf_pkg::REG_SPC && bus == pri_bus_i) begin
        cls_d = bcf_pkg::CLS_SPC_UP; // [R18]
      end else if (!in_rng) begin
        cls_d = bcf_pkg::CLS_T1_UP; // [R15]
      end
    end
  end

  // bus numbers are taken as they stand in the address phase
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cls_o   <= bcf_pkg::CLS_NONE;
      oaddr_o <= bcf_pkg::RST_WORD;
      ocmd_o  <= bcf_pkg::RST_NIB;
      xaddr_o <= bcf_pkg::RST_WORD;
      xcmd_o  <= bcf_pkg::RST_NIB;
    end else if (start_i) begin
      cls_o   <= cls_d; // [R23]
      oaddr_o <= ad_i;
      ocmd_o  <= cbe_i;
      xaddr_o <= ad_i;
      xcmd_o  <= cbe_i;
      if (cls_d == bcf_pkg::CLS_T0) begin
        xaddr_o <= {idsel_pat(dev), 5'h00, fn, regn, bcf_pkg::AD_TYPE0}; // [R09] [R10] [R11] [R12]
      end
      if (cls_d == bcf_pkg::CLS_SPC_DN || cls_d == bcf_pkg::CLS_SPC_UP) begin
        xcmd_o <= bcf_pkg::CMD_SPC; // [R19]
      end
    end
  end

endmodule : bcf_cfg_decode

// [bcf_dt_entry.sv]
/*
  single delayed transaction entry: holds one forwarded configuration
  request, drives it to the far bus master and keeps its completion.
  assumes the far master answers each request with one done or abort pulse.
*/
`timescale 1ns/100ps
module bcf_dt_entry (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        post_i,
  input  wire logic        clear_i,
  input  wire logic [31:0] q_addr_i,
  input  wire logic [3:0]  q_cmd_i,
  input  wire logic        q_sec_i,
  input  wire logic [31:0] x_addr_i,
  input  wire logic [3:0]  x_cmd_i,
  input  wire logic        spc_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic [3:0]  be_n_i,
  input  wire logic        fwd_done_i,
  input  wire logic        fwd_mabort_i,
  input  wire logic [31:0] fwd_rdata_i,
  output logic             busy_o,
  output logic             done_o,
  output logic             mabort_o,
  output logic             spc_o,
  output logic             match_o,
  output logic [31:0]      rdata_o,
  output logic             fwd_req_o,
  output logic             fwd_to_sec_o,
  output logic [31:0]      fwd_addr_o,
  output logic [3:0]       fwd_cmd_o,
  output logic [31:0]      fwd_data_o,
  output logic [3:0]       fwd_be_n_o
);

  logic [31:0] addr_q;
  logic [3:0]  cmd_q;
  logic        sec_q;

  assign match_o = busy_o && addr_q == q_addr_i && cmd_q == q_cmd_i && sec_q == q_sec_i;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_o <= 1'b0;
      spc_o  <= 1'b0;
      addr_q <= bcf_pkg::RST_WORD;
      cmd_q  <= bcf_pkg::RST_NIB;
      sec_q  <= 1'b0;
    end else if (post_i) begin
      busy_o <= 1'b1;
      spc_o  <= spc_i;
      addr_q <= q_addr_i;
      cmd_q  <= q_cmd_i;
      sec_q  <= q_sec_i;
    end else if (clear_i) begin
      busy_o <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fwd_req_o    <= 1'b0;
      fwd_to_sec_o <= 1'b0;
      fwd_addr_o   <= bcf_pkg::RST_WORD;
      fwd_cmd_o    <= bcf_pkg::RST_NIB;
      fwd_data_o   <= bcf_pkg::RST_WORD;
      fwd_be_n_o   <= bcf_pkg::RST_NIB;
    end else if (post_i) begin
      fwd_req_o    <= 1'b1; // [R13] [R16]
      fwd_to_sec_o <= !q_sec_i; // [R08]
      fwd_addr_o   <= x_addr_i; // [R19]
      fwd_cmd_o    <= x_cmd_i;
      fwd_data_o   <= wdata_i;
      fwd_be_n_o   <= be_n_i;
    end else if (fwd_done_i || fwd_mabort_i) begin
      fwd_req_o <= 1'b0;
    end
  end

  // completion flags: a completion in the clear cycle is kept
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      done_o   <= 1'b0;
      mabort_o <= 1'b0;
      rdata_o  <= bcf_pkg::RST_WORD;
    end else if (fwd_req_o && (fwd_done_i || fwd_mabort_i)) begin
      done_o   <= 1'b1;
      mabort_o <= fwd_mabort_i; // [R20]
      rdata_o  <= fwd_rdata_i;
    end else if (clear_i || post_i) begin
      done_o   <= 1'b0;
      mabort_o <= 1'b0;
    end
  end

endmodule : bcf_dt_entry

// [bcf_cfg_fwd.sv]
/*
  configuration transaction claim and forwarding logic of a two-port
  bus bridge: target side handshakes on both buses, own register access
  and delayed forwarding through one entry.
  assumes bus inputs are active-high levels already sampled on clk_i;
  the register file and far bus master sit on the same clock.
*/
`timescale 1ns/100ps
// Overview of operation
// [R01] claim own type 0 only for config command, ad 00b, idsel in address phase
// [R02] secondary type 0 and own space are never claimed from secondary
// [R03] function number ignored when claiming own type 0 access
// [R04] own access moves one dword, disconnect with first transfer if more
// [R05] own read returns all four bytes regardless of byte enables
// [R06] own access bypasses the delayed entry and completes at once
// [R07] primary type 1 to secondary bus number is claimed for type 0 translation
// [R08] type 0 is only ever generated on the secondary bus
// [R09] translated address: bits 1:0 and 15:11 zero, function and register kept
// [R10] devices 0 to 15 get a one-hot line at bit 16 plus device
// [R11] devices 16 to 30 still forwarded with upper bits zero
// [R12] device 31 register 0 makes special cycle, else upper bits zero; the code makes it only for a function 7 write
// [R13] type 0 translations are delayed and move one 32-bit word
// [R14] primary type 1 above secondary up to subordinate forwarded unchanged
// [R15] secondary type 1 write to 1f/7 outside range forwarded upstream
// [R16] type 1 forwarded writes are delayed and move one transfer
// [R17] special cycle commands on either bus are ignored, never passed
// [R18] type 1 write 1f/7 register 0 to matching bus becomes special cycle
// [R19] special cycle replaces the command, address and data unchanged
// [R20] special cycle abort not relayed, trdy on next matching repeat
// [R21] special cycle request wanting more transfers gets disconnect first phase
// [R22] retried initiator repeats the identical transaction until it completes
// [R23] bus numbers for decode are taken in each address phase
module bcf_cfg_fwd (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [7:0]  cfg_pri_bus_i,
  input  wire logic [7:0]  cfg_sec_bus_i,
  input  wire logic [7:0]  cfg_sub_bus_i,
  input  wire logic        p_adr_vld_i,
  input  wire logic [31:0] p_ad_i,
  input  wire logic [3:0]  p_cbe_i,
  input  wire logic        p_idsel_i,
  input  wire logic        p_frame_i,
  input  wire logic        p_irdy_i,
  input  wire logic        s_adr_vld_i,
  input  wire logic [31:0] s_ad_i,
  input  wire logic [3:0]  s_cbe_i,
  input  wire logic        s_frame_i,
  input  wire logic        s_irdy_i,
  input  wire logic [31:0] own_rdata_i,
  input  wire logic        fwd_done_i,
  input  wire logic        fwd_mabort_i,
  input  wire logic [31:0] fwd_rdata_i,
  output logic             p_devsel_o,
  output logic             p_trdy_o,
  output logic             p_stop_o,
  output logic             s_devsel_o,
  output logic             s_trdy_o,
  output logic             s_stop_o,
  output logic [31:0]      tgt_rdata_o,
  output logic             own_wr_o,
  output logic [5:0]       own_reg_o,
  output logic [31:0]      own_wdata_o,
  output logic [3:0]       own_be_n_o,
  output logic             fwd_req_o,
  output logic             fwd_to_sec_o,
  output logic [31:0]      fwd_addr_o,
  output logic [3:0]       fwd_cmd_o,
  output logic [31:0]      fwd_data_o,
  output logic [3:0]       fwd_be_n_o
);

  bcf_pkg::bcf_state_t st_q;
  bcf_pkg::bcf_state_t st_d;
  bcf_pkg::bcf_cls_t   cls;

  logic        bus_q;
  logic        bus_d;
  logic        devsel_d;
  logic        trdy_d;
  logic        stop_d;
  logic        xfer_q;
  logic        xfer_d;
  logic        post;
  logic        clear;
  logic        start;
  logic        start_sec;
  logic        irdy;
  logic        frame;
  logic [31:0] dat;
  logic [3:0]  be_n;
  logic [31:0] oaddr;
  logic [3:0]  ocmd;
  logic [31:0] xaddr;
  logic [3:0]  xcmd;
  logic        e_busy;
  logic        e_done;
  logic        e_mabort;
  logic        e_spc;
  logic        e_match;
  logic [31:0] e_rdata;
  logic        is_own;
  logic        is_spc;

  // only one transaction is handled at a time; primary wins a tie
  assign start     = (st_q == bcf_pkg::ST_IDLE) && (p_adr_vld_i || s_adr_vld_i);
  assign start_sec = !p_adr_vld_i;

  assign irdy  = bus_q ? s_irdy_i : p_irdy_i;
  assign frame = bus_q ? s_frame_i : p_frame_i;
  assign dat   = bus_q ? s_ad_i : p_ad_i;
  assign be_n  = bus_q ? s_cbe_i : p_cbe_i;

  assign is_own = (cls == bcf_pkg::CLS_OWN);
  assign is_spc = (cls == bcf_pkg::CLS_SPC_DN) || (cls == bcf_pkg::CLS_SPC_UP);

  bcf_cfg_decode u_dec (
    .clk_i      (clk_i),
    .rst_n_i    (rst_n_i),
    .start_i    (start),
    .from_sec_i (start_sec),
    .ad_i       (start_sec ? s_ad_i : p_ad_i),
    .cbe_i      (start_sec ? s_cbe_i : p_cbe_i),
    .idsel_i    (p_idsel_i && !start_sec),
    .pri_bus_i  (cfg_pri_bus_i),
    .sec_bus_i  (cfg_sec_bus_i),
    .sub_bus_i  (cfg_sub_bus_i),
    .cls_o      (cls),
    .oaddr_o    (oaddr),
    .ocmd_o     (ocmd),
    .xaddr_o    (xaddr),
    .xcmd_o     (xcmd)
  );

  bcf_dt_entry u_ent (
    .clk_i        (clk_i),
    .rst_n_i      (rst_n_i),
    .post_i       (post),
    .clear_i      (clear),
    .q_addr_i     (oaddr),
    .q_cmd_i      (ocmd),
    .q_sec_i      (bus_q),
    .x_addr_i     (xaddr),
    .x_cmd_i      (xcmd),
    .spc_i        (is_spc),
    .wdata_i      (dat),
    .be_n_i       (be_n),
    .fwd_done_i   (fwd_done_i),
    .fwd_mabort_i (fwd_mabort_i),
    .fwd_rdata_i  (fwd_rdata_i),
    .busy_o       (e_busy),
    .done_o       (e_done),
    .mabort_o     (e_mabort),
    .spc_o        (e_spc),
    .match_o      (e_match),
    .rdata_o      (e_rdata),
    .fwd_req_o    (fwd_req_o),
    .fwd_to_sec_o (fwd_to_sec_o),
    .fwd_addr_o   (fwd_addr_o),
    .fwd_cmd_o    (fwd_cmd_o),
    .fwd_data_o   (fwd_data_o),
    .fwd_be_n_o   (fwd_be_n_o)
  );

  // target sequencer
  always_comb begin
    st_d     = st_q;
    bus_d    = bus_q;
    devsel_d = p_devsel_o || s_devsel_o;
    trdy_d   = 1'b0;
    stop_d   = p_stop_o || s_stop_o;
    xfer_d   = xfer_q;
    post     = 1'b0;
    clear    = 1'b0;
    case (st_q)
      bcf_pkg::ST_IDLE: begin
        devsel_d = 1'b0;
        stop_d   = 1'b0;
        if (start) begin
          st_d  = bcf_pkg::ST_DEC;
          bus_d = start_sec;
        end
      end
      bcf_pkg::ST_DEC: begin
        if (cls == bcf_pkg::CLS_NONE) begin
          st_d = bcf_pkg::ST_IDLE; // [R02] [R17]
        end else if (is_own) begin
          devsel_d = 1'b1; // [R01]
          xfer_d   = 1'b1; // [R06]
          st_d     = bcf_pkg::ST_DATA;
        end else if (e_match && e_done && e_mabort && !e_spc) begin
          clear = 1'b1; // [R11]
          st_d  = bcf_pkg::ST_IDLE;
        end else begin
          devsel_d = 1'b1; // [R07] [R14] [R15] [R18]
          xfer_d   = e_match && e_done; // [R20] [R22]
          st_d     = bcf_pkg::ST_DATA;
        end
      end
      bcf_pkg::ST_DATA: begin
        if (irdy) begin
          st_d   = bcf_pkg::ST_TERM;
          trdy_d = xfer_q;
          stop_d = !xfer_q || frame; // [R04] [R21]
          if (!is_own && xfer_q) begin
            clear = 1'b1; // [R20]
          end else if (!is_own && !e_busy) begin
            post = 1'b1; // [R13] [R16]
          end
        end
      end
      bcf_pkg::ST_TERM: begin
        if (!frame) begin
          st_d     = bcf_pkg::ST_IDLE;
          devsel_d = 1'b0;
          stop_d   = 1'b0;
        end
      end
      default: begin
        st_d = bcf_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q   <= bcf_pkg::ST_IDLE;
      bus_q  <= 1'b0;
      xfer_q <= 1'b0;
    end else begin
      st_q   <= st_d;
      bus_q  <= bus_d;
      xfer_q <= xfer_d;
    end
  end

  // handshake outputs, one set per bus
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      p_devsel_o <= 1'b0;
      p_trdy_o   <= 1'b0;
      p_stop_o   <= 1'b0;
      s_devsel_o <= 1'b0;
      s_trdy_o   <= 1'b0;
      s_stop_o   <= 1'b0;
    end else begin
      p_devsel_o <= devsel_d && !bus_d;
      p_trdy_o   <= trdy_d && !bus_d;
      p_stop_o   <= stop_d && !bus_d;
      s_devsel_o <= devsel_d && bus_d; // [R08]
      s_trdy_o   <= trdy_d && bus_d;
      s_stop_o   <= stop_d && bus_d;
    end
  end

  // read data for the single transfer
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tgt_rdata_o <= bcf_pkg::RST_WORD;
    end else if (st_q == bcf_pkg::ST_DATA && irdy && xfer_q) begin
      tgt_rdata_o <= is_own ? own_rdata_i : e_rdata; // [R05]
    end
  end

  // own register port
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      own_wr_o <= 1'b0;
    end else begin
      own_wr_o <= st_q == bcf_pkg::ST_DATA && irdy && is_own
                  && ocmd == bcf_pkg::CMD_CFG_WR; // [R04] [R06]
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      own_wdata_o <= bcf_pkg::RST_WORD;
      own_be_n_o  <= bcf_pkg::RST_NIB;
    end else if (st_q == bcf_pkg::ST_DATA && irdy && is_own) begin
      own_wdata_o <= dat;
      own_be_n_o  <= be_n;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      own_reg_o <= 6'h00;
    end else if (st_q == bcf_pkg::ST_DEC && is_own) begin
      own_reg_o <= oaddr[7:2]; // [R03]
    end
  end

endmodule : bcf_cfg_fwd

// [bcf_checker.sv]
/* port assertions for bcf_cfg_fwd, bound below.
   assumes clk_i and async active-low rst_n_i. */
`timescale 1ns/100ps
module bcf_checker (
  input logic        clk_i,
  input logic        rst_n_i,
  input logic        p_adr_vld_i,
  input logic [3:0]  p_cbe_i,
  input logic        p_frame_i,
  input logic        s_adr_vld_i,
  input logic [31:0] s_ad_i,
  input logic        fwd_done_i,
  input logic        fwd_mabort_i,
  input logic        p_devsel_o,
  input logic        p_trdy_o,
  input logic        p_stop_o,
  input logic        s_devsel_o,
  input logic        own_wr_o,
  input logic        fwd_req_o,
  input logic        fwd_to_sec_o,
  input logic [31:0] fwd_addr_o,
  input logic [3:0]  fwd_cmd_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  sequence p_claim_s;
    !p_devsel_o ##1 p_devsel_o;
  endsequence
  sequence fwd_wait_s;
    fwd_req_o && !fwd_done_i && !fwd_mabort_i;
  endsequence
  pri_claim_a: assert property (p_claim_s |-> $past(p_adr_vld_i, 2) && $past(p_cbe_i[3:1], 2) == 3'h5)
    else $error("bad primary claim");
  sec_claim_a: assert property ($rose(s_devsel_o) |-> $past(s_adr_vld_i, 2) && $past(s_ad_i[1:0], 2) == 2'h1)
    else $error("bad secondary claim");
  trdy_once_a: assert property (p_trdy_o |=> !p_trdy_o)
    else $error("trdy too long");
  resp_sel_a: assert property (p_trdy_o || p_stop_o |-> p_devsel_o)
    else $error("no devsel");
  first_disc_a: assert property ($rose(p_trdy_o) && $past(p_frame_i) |-> p_stop_o)
    else $error("no disconnect");
  own_now_a: assert property (own_wr_o |-> p_trdy_o && p_devsel_o)
    else $error("own write late");
  fwd_hold_a: assert property (fwd_wait_s |=> fwd_req_o && $stable(fwd_addr_o) && $stable(fwd_cmd_o))
    else $error("request changed");
  fwd_drop_a: assert property (fwd_req_o && (fwd_done_i || fwd_mabort_i) |=> !fwd_req_o)
    else $error("request kept");
  up_type1_a: assert property (fwd_req_o && !fwd_to_sec_o |-> fwd_addr_o[1:0] == 2'h1)
    else $error("type 0 upstream");
  spc_addr_a: assert property (fwd_req_o && fwd_cmd_o == bcf_pkg::CMD_SPC |-> fwd_addr_o[15:0] == 16'hff01)
    else $error("bad spc address");
  idsel_map_a: assert property (fwd_req_o && fwd_addr_o[1:0] == 2'h0
    |-> fwd_to_sec_o && $onehot0(fwd_addr_o[31:16]) && fwd_addr_o[15:11] == 5'h0)
    else $error("bad type 0 address");
endmodule : bcf_checker
bind bcf_cfg_fwd bcf_checker bcf_checker_i (.clk_i, .rst_n_i, .p_adr_vld_i, .p_cbe_i, .p_frame_i, .s_adr_vld_i,
  .s_ad_i, .fwd_done_i, .fwd_mabort_i, .p_devsel_o, .p_trdy_o, .p_stop_o, .s_devsel_o, .own_wr_o, .fwd_req_o,
  .fwd_to_sec_o, .fwd_addr_o, .fwd_cmd_o);

// [bcf_far_model.sv]
/* far bus master model for forwarded requests.
   assumes req_i held until answered. */
`timescale 1ns/100ps
module bcf_far_model (
  input  logic        clk_i,
  input  logic        rst_n_i,
  input  logic [3:0]  delay_i,
  input  logic        req_i,
  input  logic        to_sec_i,
  input  logic [31:0] addr_i,
  input  logic [3:0]  cmd_i,
  input  logic [31:0] data_i,
  output logic             done_o,
  output logic             mabort_o,
  output logic [31:0]      rdata_o,
  output logic [31:0]      cap_addr_o,
  output logic [3:0]       cap_cmd_o,
  output logic [31:0]      cap_data_o,
  output logic             cap_sec_o
);
  logic [3:0] cnt_q;
  logic       busy_q;
  logic       nosel;
  assign nosel = (cmd_i == bcf_pkg::CMD_SPC) || (to_sec_i && addr_i[1:0] == 2'h0 && addr_i[31:16] == 16'h0);
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q    <= 4'h0;
      busy_q   <= 1'b0;
      done_o   <= 1'b0;
      mabort_o <= 1'b0;
      rdata_o  <= 32'h0;
    end else begin
      done_o   <= 1'b0;
      mabort_o <= 1'b0;
      rdata_o  <= rdata_o + 32'h1;
      if (!req_i) begin
        cnt_q  <= 4'h0;
        busy_q <= 1'b0;
      end else if (!busy_q) begin
        cnt_q <= cnt_q + 4'h1;
        if (cnt_q == delay_i) begin
          busy_q   <= 1'b1;
          done_o   <= !nosel;
          mabort_o <= nosel;
          rdata_o  <= ~addr_i;
        end
      end
    end
  end
  always_ff @(posedge clk_i) begin
    if (req_i) begin
      cap_addr_o <= addr_i;
      cap_cmd_o  <= cmd_i;
      cap_data_o <= data_i;
      cap_sec_o  <= to_sec_i;
    end
  end
endmodule : bcf_far_model

// [tb.sv]
/* tb: bench for bcf_cfg_fwd and the far model.
   assumes one initiator at a time. */
`timescale 1ns/100ps
module tb;
  logic        clk_i, rst_n_i, vld, on_sec, frm, irdy, p_idsel_i, cap_sec, r_dev, r_trdy, r_stop;
  logic        p_adr_vld_i, s_adr_vld_i, p_frame_i, s_frame_i, p_irdy_i, s_irdy_i, fwd_done_i, fwd_mabort_i;
  logic        p_devsel_o, p_trdy_o, p_stop_o, s_devsel_o, s_trdy_o, s_stop_o, own_wr_o, fwd_req_o, fwd_to_sec_o;
  logic [31:0] ad, own_rdata_i, fwd_rdata_i, r_rd, w_data, cap_addr, cap_data;
  logic [31:0] tgt_rdata_o, own_wdata_o, fwd_addr_o, fwd_data_o;
  logic [7:0]  cfg_pri_bus_i, cfg_sec_bus_i, cfg_sub_bus_i;
  logic [3:0]  cbe, dly, cap_cmd, w_be, own_be_n_o, fwd_cmd_o, fwd_be_n_o;
  logic [5:0]  own_reg_o, w_reg;
  int          n_errors, cmp_count, n_wr;
  localparam logic [3:0] WR = bcf_pkg::CMD_CFG_WR, RD = bcf_pkg::CMD_CFG_RD, SP = bcf_pkg::CMD_SPC;
  assign p_adr_vld_i = vld & ~on_sec;
  assign s_adr_vld_i = vld & on_sec;
  assign p_frame_i = frm & ~on_sec;
  assign s_frame_i = frm & on_sec;
  assign p_irdy_i = irdy & ~on_sec;
  assign s_irdy_i = irdy & on_sec;
  assign own_rdata_i = 32'h5a00_0000 | {26'h0, own_reg_o};
  bcf_cfg_fwd bcf_cfg_fwd_i (
    .clk_i, .rst_n_i, .cfg_pri_bus_i, .cfg_sec_bus_i, .cfg_sub_bus_i, .p_adr_vld_i, .p_ad_i(ad), .p_cbe_i(cbe),
    .p_idsel_i, .p_frame_i, .p_irdy_i, .s_adr_vld_i, .s_ad_i(ad), .s_cbe_i(cbe), .s_frame_i, .s_irdy_i,
    .own_rdata_i, .fwd_done_i, .fwd_mabort_i, .fwd_rdata_i, .p_devsel_o, .p_trdy_o, .p_stop_o, .s_devsel_o,
    .s_trdy_o, .s_stop_o, .tgt_rdata_o, .own_wr_o, .own_reg_o, .own_wdata_o, .own_be_n_o, .fwd_req_o,
    .fwd_to_sec_o, .fwd_addr_o, .fwd_cmd_o, .fwd_data_o, .fwd_be_n_o);
  bcf_far_model bcf_far_model_i (.clk_i, .rst_n_i, .delay_i(dly), .req_i(fwd_req_o), .to_sec_i(fwd_to_sec_o),
    .addr_i(fwd_addr_o), .cmd_i(fwd_cmd_o), .data_i(fwd_data_o), .done_o(fwd_done_i), .mabort_o(fwd_mabort_i),
    .rdata_o(fwd_rdata_i), .cap_addr_o(cap_addr), .cap_cmd_o(cap_cmd), .cap_data_o(cap_data), .cap_sec_o(cap_sec));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    if (own_wr_o === 1'b1) begin
      n_wr++;
      w_reg = own_reg_o;
      w_data = own_wdata_o;
      w_be = own_be_n_o;
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic stop_test;
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stop_test
  task automatic xact(input logic sec, sel, more, input logic [31:0] a, d, input logic [3:0] c, be);
    {r_dev, r_trdy, r_stop} = 3'h0;
    @(posedge clk_i);
    on_sec <= sec;
    vld <= 1'b1;
    ad <= a;
    cbe <= c;
    p_idsel_i <= sel;
    frm <= 1'b1;
    @(posedge clk_i);
    vld <= 1'b0;
    ad <= d;
    cbe <= be;
    frm <= more;
    irdy <= 1'b1;
    for (int i = 0; i < 8 && !(r_trdy || r_stop); i++) begin
      @(posedge clk_i);
      #1;
      r_dev |= sec ? s_devsel_o : p_devsel_o;
      r_trdy = sec ? s_trdy_o : p_trdy_o;
      r_stop = sec ? s_stop_o : p_stop_o;
      r_rd = tgt_rdata_o;
    end
    @(posedge clk_i);
    frm <= 1'b0;
    @(posedge clk_i);
    irdy <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask : xact
  task automatic noclaim(input logic sec, sel, input logic [31:0] a, input logic [3:0] c);
    xact(sec, sel, 1'b0, a, 32'h0, c, 4'h0);
    chk("no claim", 32'h0, 32'({r_dev, r_trdy, r_stop}));
  endtask : noclaim
  task automatic retry_til(input logic sec, more, input logic [31:0] a, d, input logic [3:0] c);
    for (int k = 0; k < 10; k++) begin
      xact(sec, 1'b0, more, a, d, c, 4'h0);
      if (!(r_dev && r_stop && !r_trdy)) return;
    end
    n_errors++;
    stop_test();
  endtask : retry_til
  task automatic fwd(input logic sec, more, input logic [31:0] a, d, input logic [3:0] c,
                     input logic [31:0] xa, input logic [3:0] xc, input logic ok);
    xact(sec, 1'b0, more, a, d, c, 4'h0);
    chk("first", 32'h5, 32'({r_dev, r_trdy, r_stop}));
    retry_til(sec, more, a, d, c);
    chk("far addr", xa, cap_addr);
    chk("far cmd", 32'(xc), 32'(cap_cmd));
    chk("far bus", 32'(!sec), 32'(cap_sec));
    if (c == WR) chk("far data", d, cap_data);
    chk("repeat", ok ? 32'({2'b11, more}) : 32'h0, 32'({r_dev, r_trdy, r_stop}));
    if (ok && c == RD) chk("rdata", ~xa, r_rd);
  endtask : fwd
  task automatic t_own;
    int w0;
    w0 = n_wr;
    xact(1'b0, 1'b1, 1'b0, 32'h314, 32'hcafe_f00d, WR, 4'h3);
    chk("wr flags", 32'h6, 32'({r_dev, r_trdy, r_stop}));
    chk("wr count", 32'(w0 + 1), 32'(n_wr));
    chk("wr reg", 32'h5, 32'(w_reg));
    chk("wr data", 32'hcafe_f00d, w_data);
    chk("wr be", 32'h3, 32'(w_be));
    xact(1'b0, 1'b1, 1'b1, 32'h24, 32'h0, RD, 4'hf);
    chk("rd flags", 32'h7, 32'({r_dev, r_trdy, r_stop}));
    chk("rd data", 32'h5a00_0009, r_rd);
    $display("test own done");
  endtask : t_own
  task automatic t_ignore;
    int w0;
    w0 = n_wr;
    noclaim(1'b0, 1'b0, 32'h14, WR);
    noclaim(1'b0, 1'b1, 32'h14, 4'h6);
    noclaim(1'b0, 1'b1, 32'h14, SP);
    noclaim(1'b0, 1'b1, 32'h16, WR);
    noclaim(1'b1, 1'b1, 32'h14, WR);
    noclaim(1'b1, 1'b0, 32'h2_ff01, SP);
    noclaim(1'b0, 1'b0, 32'h6_0801, RD);
    noclaim(1'b1, 1'b0, 32'h9_ff0d, RD);
    noclaim(1'b1, 1'b0, 32'h9_f70d, WR);
    noclaim(1'b1, 1'b0, 32'h3_ff0d, WR);
    chk("wr none", 32'(w0), 32'(n_wr));
    $display("test ignore done");
  endtask : t_ignore
  task automatic t_t1;
    fwd(1'b0, 1'b0, 32'h3_1025, 32'h1234_5678, WR, 32'h3_1025, WR, 1'b1);
    dly <= 4'h9;
    fwd(1'b0, 1'b0, 32'h5_0a05, 32'h0, RD, 32'h5_0a05, RD, 1'b1);
    fwd(1'b1, 1'b0, 32'h9_ff0d, 32'h0bad_cafe, WR, 32'h9_ff0d, WR, 1'b1);
    dly <= 4'h0;
    fwd(1'b0, 1'b1, 32'h2_ff01, 32'habcd, WR, 32'h2_ff01, SP, 1'b1);
    fwd(1'b1, 1'b0, 32'h1_ff01, 32'h1357, WR, 32'h1_ff01, SP, 1'b1);
    $display("test type 1 done");
  endtask : t_t1
  task automatic t_xlate;
    logic [4:0] dv [6] = '{5'h00, 5'h05, 5'h0f, 5'h10, 5'h1e, 5'h1f};
    logic [5:0] rg;
    logic [31:0] sel;
    cfg_sec_bus_i <= 8'h07;
    cfg_sub_bus_i <= 8'h07;
    for (int n = 0; n < 6; n++) begin
      rg = (dv[n] == 5'h1f) ? 6'h00 : 6'h04;
      sel = (dv[n] < 5'h10) ? (32'h1 << (16 + dv[n])) : 32'h0;
      dly <= n[0] ? 4'h9 : 4'h0;
      fwd(1'b0, 1'b0, {8'h0, 8'h07, dv[n], 3'h2, rg, 2'h1}, 32'h0, RD,
          sel | {16'h0, 5'h0, 3'h2, rg, 2'h0}, RD, dv[n] < 5'h10);
    end
    $display("test translate done");
  endtask : t_xlate
  initial begin
    rst_n_i = 1'b0;
    {vld, on_sec, frm, irdy, p_idsel_i} = 5'h0;
    ad = 32'h0;
    cbe = 4'h0;
    dly = 4'h0;
    cfg_pri_bus_i = 8'h01;
    cfg_sec_bus_i = 8'h02;
    cfg_sub_bus_i = 8'h05;
    n_errors = 0;
    cmp_count = 0;
    n_wr = 0;
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_own();
    t_ignore();
    t_t1();
    t_xlate();
    stop_test();
  end
endmodule : tb
